// ===== config_port_access_decoder_bench.sv
// self-checking bench of the configuration port decoder
// assumes the host model drives every bus input at the falling edge
`timescale 1ns/1ps
`include "cpad_map.svh"
module config_port_access_decoder_bench;
   logic clk, rstn, mode_strap, reset_out;
   logic [15:0] sa;
   logic [7:0] sd_in, sd_out, ldn;
   logic iow_n, ior_n, aen, sd_oe, cfg_active, soft_reset;
   int errors = 0;
   int n_checks = 0;
   int n_soft = 0;
   logic [7:0] r_idx [5] = '{8'h07, 8'h26, 8'h02, 8'h10, 8'h26};
   logic [7:0] r_dat [5] = '{8'ha5, 8'h35, 8'h00, 8'h77, 8'hf0};
   logic [7:0] r_exp [5] = '{8'ha5, 8'h34, 8'h00, 8'h00, 8'hf0};
   logic [7:0] d;
   logic oe;
   // ==========
   // design and host
   cpad_decoder dut (.clk(clk), .rstn(rstn), .mode_strap(mode_strap), .reset_out(reset_out),
      .isa_sa(sa), .isa_sd_in(sd_in), .isa_iow_n(iow_n), .isa_ior_n(ior_n), .isa_aen(aen),
      .isa_sd_out(sd_out), .isa_sd_oe(sd_oe), .cfg_active(cfg_active), .ldn(ldn),
      .soft_reset(soft_reset));
   cpad_host_model h (.clk(clk), .sd_out(sd_out), .sd_oe(sd_oe), .sa(sa), .sd_in(sd_in),
      .iow_n(iow_n), .ior_n(ior_n), .aen(aen));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (soft_reset === 1'b1) n_soft <= n_soft + 1;
   end
   // ==========
   // checking
   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic finish_test();
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic rdchk(input string name, input logic [15:0] a, input logic eoe, input logic [7:0] ed);
      logic [7:0] rd;
      logic roe;
      h.rd(a, 1'b0, rd, roe);
      check(name, 16'(roe), 16'(eoe));
      if (eoe) check(name, 16'(rd), 16'(ed));
   endtask : rdchk
   task automatic hard_reset(input logic s);
      rstn = 1'b0;
      mode_strap = s;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      // first edge after release loads the strap, decode starts later
      repeat (2) @(negedge clk);
   endtask : hard_reset
   initial begin
      repeat (20000) @(posedge clk);
      check("timeout", 16'h0001, 16'h0000);
      finish_test();
   end
   // ==========
   // main sequence
   initial begin
      reset_out = 1'b0;
      hard_reset(1'b0);
      rdchk("locked key read", 16'h03f0, 1'b0, 8'h00);
      h.wr(16'h03f0, `CPAD_KEY_ENTER, 1'b0);
      rdchk("key after unlock", 16'h03f0, 1'b1, 8'h00);
      check("unlock", 16'(cfg_active), 16'h0001);
      for (int i = 0; i < 5; i++) begin
         h.wr(16'h03f0, r_idx[i], 1'b0);
         h.wr(16'h03f1, r_dat[i], 1'b0);
         rdchk("data port", 16'h03f1, 1'b1, r_exp[i]);
         rdchk("index read", 16'h03f0, 1'b1, r_idx[i]);
      end
      check("ldn", 16'(ldn), 16'h00a5);
      h.wr(16'h03f0, `CPAD_KEY_EXIT, 1'b1);
      check("aen write", 16'(cfg_active), 16'h0001);
      h.rd(16'h03f0, 1'b1, d, oe);
      check("aen read", 16'(oe), 16'h0000);
      h.relocate(16'h03f0, 16'hf235);
      rdchk("old base", 16'h03f0, 1'b0, 8'h00);
      rdchk("new base", 16'h0234, 1'b1, 8'h27);
      rdchk("base high", 16'h0235, 1'b1, 8'h02);
      h.wr(16'h0234, `CPAD_KEY_EXIT, 1'b0);
      check("lock", 16'(cfg_active), 16'h0000);
      rdchk("locked data", 16'h0235, 1'b0, 8'h00);
      h.wr(16'h0234, `CPAD_KEY_ENTER, 1'b0);
      h.wr(16'h0234, 8'h02, 1'b0);
      h.wr(16'h0235, 8'h01, 1'b0);
      repeat (2) @(negedge clk);
      check("soft pulse", 16'(n_soft), 16'h0001);
      check("soft ldn", 16'(ldn), 16'h0000);
      rdchk("soft keeps base", 16'h0234, 1'b1, 8'h02);
      // reset pin with strap high moves decode to the alternate base
      mode_strap = 1'b1;
      reset_out = 1'b1;
      @(negedge clk);
      reset_out = 1'b0;
      repeat (2) @(negedge clk);
      check("pin reset lock", 16'(cfg_active), 16'h0000);
      h.wr(16'h0370, `CPAD_KEY_ENTER, 1'b0);
      check("strap high", 16'(cfg_active), 16'h0001);
      h.wr(16'h0370, 8'h26, 1'b0);
      rdchk("low strap1", 16'h0371, 1'b1, 8'h70);
      h.wr(16'h0370, 8'h27, 1'b0);
      rdchk("high strap1", 16'h0371, 1'b1, 8'h03);
      hard_reset(1'b0);
      rdchk("locked again", 16'h03f0, 1'b0, 8'h00);
      h.wr(16'h03f0, `CPAD_KEY_ENTER, 1'b0);
      h.wr(16'h03f0, 8'h26, 1'b0);
      rdchk("low strap0", 16'h03f1, 1'b1, 8'hf0);
      finish_test();
   end
endmodule : config_port_access_decoder_bench

// ===== cpad_base_regs.sv
// relocatable base address registers of the configuration ports
// assumes write pulses are already qualified by bus decode and state
`timescale 1ns/1ps
`include "cpad_map.svh"
module cpad_base_regs (
   input wire logic clk,
   input wire logic rstn,
   input wire logic strap,
   input wire logic hard_reset,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   output logic [7:0] base_lo,
   output logic [7:0] base_hi,
   output logic [15:0] active_base,
   output logic ready
);
   // ==========================================
   // registers
   logic load_pend;
   logic next_load_pend;
   logic [7:0] next_base_lo;
   logic [7:0] next_base_hi;
   logic [15:0] next_active_base;

   always_comb begin
      next_load_pend = 1'b0;
      next_base_lo = base_lo;
      next_base_hi = base_hi;
      next_active_base = active_base;
      // strap is sampled after reset release, never under the async reset
      if (load_pend || hard_reset) begin // [RULE1] [RULE14]
         next_base_lo = strap ? `CPAD_LOW_STRAP1 : `CPAD_LOW_STRAP0;
         next_base_hi = `CPAD_HIGH_RST;
         next_active_base = strap ? `CPAD_BASE_STRAP1 : `CPAD_BASE_STRAP0;
      end else begin
         if (wr_lo) begin
            next_base_lo = wdata & `CPAD_LOW_MASK; // [RULE11]
         end
         if (wr_hi) begin
            next_base_hi = wdata & `CPAD_HIGH_MASK; // [RULE11]
            // decode moves only here; a low write alone is staged
            next_active_base = {wdata & `CPAD_HIGH_MASK, base_lo}; // [RULE12]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         load_pend <= 1'b1;
         base_lo <= `CPAD_LOW_STRAP0;
         base_hi <= `CPAD_HIGH_RST;
         active_base <= `CPAD_BASE_STRAP0;
      end else begin
         load_pend <= next_load_pend;
         base_lo <= next_base_lo;
         base_hi <= next_base_hi;
         active_base <= next_active_base;
      end
   end

   assign ready = !load_pend;

   // ==========================================
   // assertions
   property p_strap_load;
      @(posedge clk) disable iff (!rstn)
      (load_pend || hard_reset) |=> (active_base == ($past(strap) ? `CPAD_BASE_STRAP1 : `CPAD_BASE_STRAP0));
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("base not loaded from strap"); // [RULE1]

   property p_hard_regs;
      @(posedge clk) disable iff (!rstn)
      hard_reset |=> base_hi == `CPAD_HIGH_RST && base_lo == ($past(strap) ? `CPAD_LOW_STRAP1 : `CPAD_LOW_STRAP0);
   endproperty
   a_hard_regs: assert property (p_hard_regs) else $error("base regs wrong after hard reset"); // [RULE14]

   property p_even_range;
      @(posedge clk) disable iff (!rstn)
      active_base[0] == 1'b0 && active_base[15:12] == 4'h0 && base_hi[7:4] == 4'h0;
   endproperty
   a_even_range: assert property (p_even_range) else $error("base odd or out of range"); // [RULE11]

   property p_lo_no_move;
      @(posedge clk) disable iff (!rstn)
      (wr_lo && !wr_hi && ready && !hard_reset) |=> $stable(active_base);
   endproperty
   a_lo_no_move: assert property (p_lo_no_move) else $error("low byte write moved decode"); // [RULE12]

   property p_hi_move;
      @(posedge clk) disable iff (!rstn)
      (wr_hi && ready && !hard_reset) |=> active_base == {4'h0, $past(wdata[3:0]), $past(base_lo)};
   endproperty
   a_hi_move: assert property (p_hi_move) else $error("high byte write did not move decode"); // [RULE12]
endmodule : cpad_base_regs

// ===== cpad_decoder.sv
// configuration index/data port decoder on the isa i/o bus
// assumes isa strobes and address are synchronous to clk
`timescale 1ns/1ps
`include "cpad_map.svh"
// Functional notes
// RULE1: strap selects default base 03f0 or 0370
// RULE2: index at base, data at base plus one
// RULE3: no port cycle taken while aen high
// RULE4: index and data only in configuration state
// RULE5: key 55 enters configuration state
// RULE6: key aa leaves configuration state
// RULE7: key port read floats when locked
// RULE8: key port reads 00 until index written
// RULE9: later reads return last written index
// RULE10: base low at index 26, high 27
// RULE11: base is even and below 1000h
// RULE12: only high byte write moves decode
// RULE13: host writes low byte then high byte
// RULE14: hard reset reloads base from strap
// RULE15: hard reset from power reset or reset pin
// RULE16: control bit0 soft reset keeps base
// RULE17: data port reaches register chosen by index
// RULE18: all port cycles complete without wait states
module cpad_decoder (
   input wire logic clk,
   input wire logic rstn,
   input wire logic mode_strap,
   input wire logic reset_out,
   input wire logic [15:0] isa_sa,
   input wire logic [7:0] isa_sd_in,
   input wire logic isa_iow_n,
   input wire logic isa_ior_n,
   input wire logic isa_aen,
   output logic [7:0] isa_sd_out,
   output logic isa_sd_oe,
   output logic cfg_active,
   output logic [7:0] ldn,
   output logic soft_reset
);
   // ==========================================
   // decode
   cpad_pkg::cpad_state_t state;
   cpad_pkg::cpad_state_t next_state;
   logic [7:0] index;
   logic [7:0] next_index;
   logic idx_written;
   logic next_idx_written;
   logic [7:0] next_ldn;
   logic next_soft_reset;
   logic [7:0] next_sd_out;
   logic iow_q;
   logic [7:0] base_lo;
   logic [7:0] base_hi;
   logic [15:0] active_base;
   logic [15:0] data_addr;
   logic ready;
   logic idx_hit;
   logic dat_hit;
   logic wr_stb;
   logic wr_lo;
   logic wr_hi;
   logic in_cfg;

   assign in_cfg = (state == cpad_pkg::cpad_config);
   assign data_addr = active_base + `CPAD_DATA_OFS; // [RULE2]
   assign idx_hit = ready && !isa_aen && (isa_sa == active_base); // [RULE2] [RULE3]
   assign dat_hit = ready && !isa_aen && (isa_sa == data_addr); // [RULE2] [RULE3]
   // a write is taken once, on the falling edge of iow
   assign wr_stb = iow_q && !isa_iow_n;
   assign wr_lo = wr_stb && dat_hit && in_cfg && (index == `CPAD_IDX_BASE_LO); // [RULE10] [RULE17]
   assign wr_hi = wr_stb && dat_hit && in_cfg && (index == `CPAD_IDX_BASE_HI); // [RULE10] [RULE17]

   // neither port drives the bus while locked; the key port takes only writes then
   assign isa_sd_oe = !isa_ior_n && in_cfg && (idx_hit || dat_hit); // [RULE4] [RULE7]
   assign cfg_active = in_cfg;

   cpad_base_regs u_base (
      .clk(clk),
      .rstn(rstn),
      .strap(mode_strap),
      .hard_reset(reset_out),
      .wr_lo(wr_lo),
      .wr_hi(wr_hi),
      .wdata(isa_sd_in),
      .base_lo(base_lo),
      .base_hi(base_hi),
      .active_base(active_base),
      .ready(ready)
   );

   // ==========================================
   // state and registers
   always_comb begin
      next_state = state;
      next_index = index;
      next_idx_written = idx_written;
      next_ldn = ldn;
      next_soft_reset = 1'b0;
      if (wr_stb && idx_hit) begin
         unique case (state)
            cpad_pkg::cpad_locked: begin
               if (isa_sd_in == `CPAD_KEY_ENTER) begin // [RULE5]
                  next_state = cpad_pkg::cpad_config;
                  next_idx_written = 1'b0; // [RULE8]
               end
            end
            cpad_pkg::cpad_config: begin
               if (isa_sd_in == `CPAD_KEY_EXIT) begin // [RULE6]
                  next_state = cpad_pkg::cpad_locked;
               end else begin
                  next_index = isa_sd_in; // [RULE9]
                  next_idx_written = 1'b1;
               end
            end
         endcase
      end
      if (wr_stb && dat_hit && in_cfg) begin // [RULE4] [RULE17]
         if (index == `CPAD_IDX_LDN) begin
            next_ldn = isa_sd_in;
         end
         if (index == `CPAD_IDX_CTRL && isa_sd_in[`CPAD_SOFT_RST_BIT]) begin // [RULE16]
            next_soft_reset = 1'b1;
            next_ldn = `CPAD_LDN_RST;
         end
      end
      // a mid-cycle reset pin wipes the port state like power-up
      if (reset_out) begin // [RULE15]
         next_state = cpad_pkg::cpad_locked;
         next_index = `CPAD_INDEX_RST;
         next_idx_written = 1'b0;
         next_ldn = `CPAD_LDN_RST;
         // hard reset wins over a soft reset write in the same cycle
         next_soft_reset = 1'b0;
      end
   end

   // read data is registered every cycle; zero wait states on every read
   always_comb begin
      next_sd_out = 8'h00;
      if (idx_hit) begin
         next_sd_out = idx_written ? index : `CPAD_KEY_READ; // [RULE8] [RULE9] [RULE18]
      end else if (dat_hit) begin
         unique case (index) // [RULE17]
            `CPAD_IDX_LDN: next_sd_out = ldn;
            `CPAD_IDX_BASE_LO: next_sd_out = base_lo; // [RULE10]
            `CPAD_IDX_BASE_HI: next_sd_out = base_hi; // [RULE10]
            default: next_sd_out = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= cpad_pkg::cpad_locked;
         index <= `CPAD_INDEX_RST;
         idx_written <= 1'b0;
         ldn <= `CPAD_LDN_RST;
         soft_reset <= 1'b0;
         isa_sd_out <= 8'h00;
         iow_q <= 1'b1;
      end else begin
         state <= next_state;
         index <= next_index;
         idx_written <= next_idx_written;
         ldn <= next_ldn;
         soft_reset <= next_soft_reset;
         isa_sd_out <= next_sd_out;
         iow_q <= isa_iow_n;
      end
   end

   // ==========================================
   // assertions
   property p_aen_float;
      @(posedge clk) disable iff (!rstn)
      isa_aen |-> !isa_sd_oe;
   endproperty
   a_aen_float: assert property (p_aen_float) else $error("drove bus with aen high"); // [RULE3]

   property p_locked_float;
      @(posedge clk) disable iff (!rstn)
      !in_cfg |-> !isa_sd_oe;
   endproperty
   a_locked_float: assert property (p_locked_float) else $error("drove bus while locked"); // [RULE7]

   property p_enter;
      @(posedge clk) disable iff (!rstn)
      (wr_stb && idx_hit && !in_cfg && isa_sd_in == `CPAD_KEY_ENTER && !reset_out) |=> in_cfg;
   endproperty
   a_enter: assert property (p_enter) else $error("enter key ignored"); // [RULE5]

   property p_exit;
      @(posedge clk) disable iff (!rstn)
      (wr_stb && idx_hit && in_cfg && isa_sd_in == `CPAD_KEY_EXIT) |=> !in_cfg;
   endproperty
   a_exit: assert property (p_exit) else $error("exit key ignored"); // [RULE6]

   property p_key_read;
      @(posedge clk) disable iff (!rstn)
      (in_cfg && !idx_written && idx_hit) |=> isa_sd_out == `CPAD_KEY_READ;
   endproperty
   a_key_read: assert property (p_key_read) else $error("key port not zero after unlock"); // [RULE8]

   property p_index_read;
      @(posedge clk) disable iff (!rstn)
      (wr_stb && idx_hit && in_cfg && isa_sd_in != `CPAD_KEY_EXIT && !reset_out)
         ##1 idx_hit |=> isa_sd_out == $past(isa_sd_in, 2);
   endproperty
   a_index_read: assert property (p_index_read) else $error("index read back wrong"); // [RULE9]

   property p_locked_ignore;
      @(posedge clk) disable iff (!rstn)
      (!in_cfg && !reset_out) |=> $stable(ldn) && $stable(index);
   endproperty
   a_locked_ignore: assert property (p_locked_ignore) else $error("register changed while locked"); // [RULE4]

   property p_soft;
      @(posedge clk) disable iff (!rstn)
      soft_reset |-> ldn == `CPAD_LDN_RST && $stable(active_base);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset wrong"); // [RULE16]

   c_enter: cover property (@(posedge clk) disable iff (!rstn) !in_cfg ##1 in_cfg);
   c_relocate: cover property (@(posedge clk) disable iff (!rstn) wr_lo ##[1:20] wr_hi);
   c_exit: cover property (@(posedge clk) disable iff (!rstn) in_cfg ##1 !in_cfg);
endmodule : cpad_decoder

// ===== cpad_host_model.sv
// isa host bus master model issuing configuration port cycles
// assumes the bench calls its tasks and clk is the bus clock
`timescale 1ns/1ps
module cpad_host_model (
   input wire logic clk,
   input wire logic [7:0] sd_out,
   input wire logic sd_oe,
   output logic [15:0] sa,
   output logic [7:0] sd_in,
   output logic iow_n,
   output logic ior_n,
   output logic aen
);
   // ==========
   // bus cycles
   initial begin
      sa = 16'h0000;
      sd_in = 8'h00;
      iow_n = 1'b1;
      ior_n = 1'b1;
      aen = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic q);
      @(negedge clk);
      sa = a;
      sd_in = d;
      aen = q;
      @(negedge clk);
      iow_n = 1'b0;
      @(negedge clk);
      iow_n = 1'b1;
      // released bus must not keep the last byte
      sd_in = ~d;
      aen = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic q, output logic [7:0] d, output logic oe);
      @(negedge clk);
      sa = a;
      aen = q;
      ior_n = 1'b0;
      // a single cycle, no wait states allowed
      @(negedge clk);
      d = sd_out;
      oe = sd_oe;
      ior_n = 1'b1;
      aen = 1'b0;
   endtask : rd
   task automatic relocate(input logic [15:0] base, input logic [15:0] nb);
      wr(base, 8'h26, 1'b0);
      wr(base + 16'h0001, nb[7:0], 1'b0);
      wr(base, 8'h27, 1'b0);
      wr(base + 16'h0001, nb[15:8], 1'b0);
   endtask : relocate
endmodule : cpad_host_model

// ===== cpad_map.svh
// constants of the configuration port access decoder
// assumes inclusion by bare name from the design files
`ifndef CPAD_MAP_SVH
`define CPAD_MAP_SVH
`define CPAD_BASE_STRAP0 16'h03f0
`define CPAD_BASE_STRAP1 16'h0370
`define CPAD_LOW_STRAP0 8'hf0
`define CPAD_LOW_STRAP1 8'h70
`define CPAD_HIGH_RST 8'h03
`define CPAD_LOW_MASK 8'hfe
`define CPAD_HIGH_MASK 8'h0f
`define CPAD_DATA_OFS 16'h0001
`define CPAD_KEY_ENTER 8'h55
`define CPAD_KEY_EXIT 8'haa
`define CPAD_KEY_READ 8'h00
`define CPAD_IDX_CTRL 8'h02
`define CPAD_IDX_LDN 8'h07
`define CPAD_IDX_BASE_LO 8'h26
`define CPAD_IDX_BASE_HI 8'h27
`define CPAD_SOFT_RST_BIT 0
`define CPAD_LDN_RST 8'h00
`define CPAD_INDEX_RST 8'h00
`endif

// ===== cpad_pkg.sv
// types of the configuration port access decoder
// assumes nothing beyond a SystemVerilog compiler
package cpad_pkg;
   typedef enum logic {cpad_locked, cpad_config} cpad_state_t;
endpackage : cpad_pkg
